// ==== design/dsig_pkg.sv ====
// Constants for the debug security ID gate
`default_nettype none
package dsig_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [31:0] DSIG_ADR_LINK_CTRL = 32'h0000_0000;
  localparam logic [31:0] DSIG_ADR_STATUS = 32'h0000_0004;
  localparam logic [31:0] DSIG_ADR_PORT_MODE = 32'h0000_0008;
  localparam logic [31:0] DSIG_ADR_PORT_DATA = 32'h0000_000C;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] DSIG_LINK_CTRL_RST = 2'h0;
  localparam logic [7:0] DSIG_PORT_MODE_RST = 8'h00;
  localparam logic [7:0] DSIG_PORT_DATA_RST = 8'h00;
  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int DSIG_CTRL_LINK_SEL = 0;
  localparam int DSIG_CTRL_MON_EN = 1;
  localparam int DSIG_HANDSHAKE_BIT = 0;
  localparam int DSIG_ST_AUTH = 0;
  localparam int DSIG_ST_EMU = 1;
  localparam int DSIG_ST_BREAK_OK = 2;
  localparam int DSIG_ST_MON_OK = 3;
  localparam int DSIG_ST_BROKEN = 4;
  localparam int DSIG_ST_LINK_SEL = 5;
  // ----------------------------------------
  // Security ID
  // ----------------------------------------
  localparam logic [31:0] DSIG_ID_FIRST_ADDR = 32'h0000_0070;
  localparam logic [31:0] DSIG_ID_LAST_ADDR = 32'h0000_0079;
  localparam int DSIG_ID_BYTES = 10;
  localparam int DSIG_ID_BITS = 80;
  localparam int DSIG_PERMIT_BIT = 79;
  localparam logic [6:0] DSIG_ID_LAST_BIT = 7'h4F;
  localparam logic [6:0] DSIG_BITCNT_RST = 7'h00;
endpackage
`default_nettype wire

// ==== design/dsig_gate.sv ====
// Debug security ID gate with Wishbone registers and serial ID link
//
// Overview of operation
// - Stored ten-byte ID sits in flash bytes 0x70 to 0x79.
// - Matching supplied ID releases flash readout and emulator access.
// - Bit 7 of byte 0x79 permits emulator use when one.
// - Permit flag zero blocks debugging even with a matching ID.
// - Forced break blocked by irq disable, masked link irq, standby with irq release off, stopped main clock on async link.
// - Monitor and memory modify also blocked by async clock mismatch.
// - Monitor activity releases standby on clocked link or clocked async link.
// - Memory modify never writes protected-sequence peripheral registers.
// - Handshake mode bit stays zero; user cannot write handshake data bit.
// - Monitor drives handshake pin; user read-modify-write cannot corrupt it.
// - Self-programming over monitor area disables debug function.
// - Link channel is set by the monitor only, not user code.
// - Selected link's interrupt must stay unmasked for debugging.
`timescale 1ns/1ps
`default_nettype none
module dsig_gate (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic monitor_access_i,
  // Flash and CPU status
  input wire logic [79:0] flash_id_i,
  input wire logic global_interrupt_disable_i,
  input wire logic async_receive_end_irq_mask_i,
  input wire logic clocked_transfer_end_irq_mask_i,
  input wire logic standby_i,
  input wire logic standby_irq_release_off_i,
  input wire logic main_clock_on_i,
  input wire logic async_clock_mismatch_i,
  input wire logic self_prog_monitor_hit_i,
  // Debug requests
  input wire logic break_req_i,
  input wire logic monitor_activity_i,
  input wire logic direct_memory_modify_req_i,
  input wire logic protected_reg_target_i,
  // Link
  input wire logic link_clk_i,
  input wire logic link_frame_i,
  input wire logic link_data_i,
  // Gate outputs
  output logic flash_read_en_o,
  output logic emulator_en_o,
  output logic forced_break_o,
  output logic direct_memory_modify_wr_o,
  output logic standby_release_o,
  output logic debug_handshake_pin_o,
  output logic debug_handshake_pin_oe_o
);
  // ----------------------------------------
  // Link domain: ID shifter
  // ----------------------------------------
  logic lrst_s1, lrst_s2;
  logic [79:0] shreg, next_shreg;
  logic [79:0] hold, next_hold;
  logic [6:0] bitcnt, next_bitcnt;
  logic req_tgl, next_req_tgl;
  logic ack_s1, ack_s2;
  logic ack_tgl;

  always_ff @(posedge link_clk_i) begin
    lrst_s1 <= rst_i;
    lrst_s2 <= lrst_s1;
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
  end

  always_comb begin
    next_shreg = shreg;
    next_hold = hold;
    next_bitcnt = bitcnt;
    next_req_tgl = req_tgl;
    if (!link_frame_i) begin
      next_bitcnt = dsig_pkg::DSIG_BITCNT_RST;
    end else if (bitcnt <= dsig_pkg::DSIG_ID_LAST_BIT) begin
      // First byte received belongs to the lowest ID address
      next_shreg = {shreg[78:0], link_data_i};
      next_bitcnt = bitcnt + 7'h01;
      if (bitcnt == dsig_pkg::DSIG_ID_LAST_BIT && req_tgl == ack_s2) begin
        next_hold = {shreg[78:0], link_data_i};
        next_req_tgl = ~req_tgl;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst_s2) begin
      shreg <= '0;
      hold <= '0;
      bitcnt <= dsig_pkg::DSIG_BITCNT_RST;
      req_tgl <= 1'b0;
    end else begin
      shreg <= next_shreg;
      hold <= next_hold;
      bitcnt <= next_bitcnt;
      req_tgl <= next_req_tgl;
    end
  end

  // ----------------------------------------
  // System domain: ID compare
  // ----------------------------------------
  logic req_s1, req_s2, req_s3;
  logic id_event;
  logic [9:0] byte_match;
  logic all_match;
  logic auth, next_auth;
  logic broken, next_broken;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end
  assign id_event = req_s2 ^ req_s3;
  assign ack_tgl = req_s3;

  genvar gi;
  generate
    for (gi = 0; gi < dsig_pkg::DSIG_ID_BYTES; gi++) begin : g_byte
      // Supplied byte gi against flash byte at 0x70 + gi
      assign byte_match[gi] = hold[79-8*gi -: 8] == flash_id_i[8*gi +: 8];
    end
  endgenerate
  assign all_match = &byte_match;

  always_comb begin
    next_auth = auth;
    next_broken = broken | self_prog_monitor_hit_i;
    if (id_event) begin
      next_auth = all_match;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auth <= 1'b0;
      broken <= 1'b0;
    end else begin
      auth <= next_auth;
      broken <= next_broken;
    end
  end

  // ----------------------------------------
  // Registers and Wishbone slave
  // ----------------------------------------
  logic [1:0] link_ctrl, next_link_ctrl;
  logic [7:0] port_mode, next_port_mode;
  logic [7:0] port_data, next_port_data;
  logic [31:0] next_dat;
  logic ack, next_ack;
  logic wr;
  logic [5:0] status;
  logic link_sel;

  assign link_sel = link_ctrl[dsig_pkg::DSIG_CTRL_LINK_SEL];
  assign wr = cyc_i & stb_i & we_i & ack & sel_i[0];

  always_comb begin
    next_link_ctrl = link_ctrl;
    next_port_mode = port_mode;
    next_port_data = port_data;
    next_ack = cyc_i & stb_i & ~ack;
    next_dat = 32'h0000_0000;
    if (wr && adr_i == dsig_pkg::DSIG_ADR_LINK_CTRL) begin
      if (monitor_access_i) begin
        next_link_ctrl = dat_i[1:0];
      end
    end else if (wr && adr_i == dsig_pkg::DSIG_ADR_PORT_MODE) begin
      next_port_mode = {dat_i[7:1], 1'b0};
    end else if (wr && adr_i == dsig_pkg::DSIG_ADR_PORT_DATA) begin
      next_port_data[7:1] = dat_i[7:1];
      if (monitor_access_i) begin
        next_port_data[0] = dat_i[0];
      end
    end
    if (adr_i == dsig_pkg::DSIG_ADR_LINK_CTRL) begin
      next_dat[1:0] = link_ctrl;
    end else if (adr_i == dsig_pkg::DSIG_ADR_STATUS) begin
      next_dat[5:0] = status;
    end else if (adr_i == dsig_pkg::DSIG_ADR_PORT_MODE) begin
      next_dat[7:0] = port_mode;
    end else if (adr_i == dsig_pkg::DSIG_ADR_PORT_DATA) begin
      next_dat[7:0] = port_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_ctrl <= dsig_pkg::DSIG_LINK_CTRL_RST;
      port_mode <= dsig_pkg::DSIG_PORT_MODE_RST;
      port_data <= dsig_pkg::DSIG_PORT_DATA_RST;
      ack <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      link_ctrl <= next_link_ctrl;
      port_mode <= next_port_mode;
      port_data <= next_port_data;
      ack <= next_ack;
      dat_o <= next_dat;
    end
  end
  assign ack_o = ack;

  // ----------------------------------------
  // Debug gating
  // ----------------------------------------
  logic link_irq_masked, break_ok, mon_ok, emu;

  assign link_irq_masked = link_sel ? clocked_transfer_end_irq_mask_i
                                    : async_receive_end_irq_mask_i;
  assign break_ok = ~global_interrupt_disable_i & ~link_irq_masked
                  & ~(standby_i & standby_irq_release_off_i)
                  & ~(~link_sel & ~main_clock_on_i);
  assign mon_ok = break_ok & ~(~link_sel & async_clock_mismatch_i);
  assign emu = auth & flash_id_i[dsig_pkg::DSIG_PERMIT_BIT] & ~broken;
  assign status = {link_sel, broken, mon_ok, break_ok, emu, auth};

  assign flash_read_en_o = auth;
  assign emulator_en_o = emu;
  assign forced_break_o = emu & break_req_i & break_ok;
  assign direct_memory_modify_wr_o = emu & direct_memory_modify_req_i & mon_ok
                                   & link_ctrl[dsig_pkg::DSIG_CTRL_MON_EN]
                                   & ~protected_reg_target_i;
  assign standby_release_o = emu & standby_i & monitor_activity_i
                           & link_ctrl[dsig_pkg::DSIG_CTRL_MON_EN]
                           & (link_sel | main_clock_on_i);
  assign debug_handshake_pin_o = port_data[dsig_pkg::DSIG_HANDSHAKE_BIT];
  assign debug_handshake_pin_oe_o = emu & ~port_mode[0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_id_ok;
    id_event && all_match;
  endsequence
  sequence s_id_bad;
    id_event && !all_match;
  endsequence

  a_auth_match: assert property (@(posedge clk_i) disable iff (rst_i)
    s_id_ok |=> flash_read_en_o)
    else $error("ID match did not release");
  a_auth_mismatch: assert property (@(posedge clk_i) disable iff (rst_i)
    s_id_bad |=> !flash_read_en_o && !emulator_en_o)
    else $error("ID mismatch left access open");
  a_permit_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !flash_id_i[dsig_pkg::DSIG_PERMIT_BIT] |-> !emulator_en_o)
    else $error("Emulator enabled with permit flag clear");
  a_break_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    (global_interrupt_disable_i || (!link_sel && !main_clock_on_i)) |-> !forced_break_o)
    else $error("Forced break taken while blocked");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    (!link_sel && async_receive_end_irq_mask_i) |-> !forced_break_o)
    else $error("Forced break with link irq masked");
  a_clk_mismatch: assert property (@(posedge clk_i) disable iff (rst_i)
    (!link_sel && async_clock_mismatch_i) |-> !direct_memory_modify_wr_o)
    else $error("Memory modify under clock mismatch");
  a_standby_rel: assert property (@(posedge clk_i) disable iff (rst_i)
    standby_release_o |-> (link_sel || main_clock_on_i) && monitor_activity_i)
    else $error("Standby released without clock");
  a_modify_protect: assert property (@(posedge clk_i) disable iff (rst_i)
    protected_reg_target_i |-> !direct_memory_modify_wr_o)
    else $error("Protected register modified");
  a_mode_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == dsig_pkg::DSIG_ADR_PORT_MODE) |=> !port_mode[0])
    else $error("Handshake mode bit set");
  a_pin_owner: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && !monitor_access_i) |=> $stable(debug_handshake_pin_o))
    else $error("User write changed handshake pin");
  a_monitor_lost: assert property (@(posedge clk_i) disable iff (rst_i)
    self_prog_monitor_hit_i |=> !emulator_en_o [*4])
    else $error("Debug alive after monitor overwrite");
  a_link_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && !monitor_access_i) |=> $stable(link_ctrl))
    else $error("User code changed link channel");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Ack held two cycles");
endmodule
`default_nettype wire

// ==== bench/dsig_emu_model.sv ====
// Emulator-side model driving the ID link
`timescale 1ns/1ps
`default_nettype none
module dsig_emu_model (
  // Link
  output logic link_clk_o,
  output logic link_frame_o,
  output logic link_data_o
);
  initial begin
    link_clk_o = 1'b0;
    link_frame_o = 1'b0;
    link_data_o = 1'b0;
  end
  // Clock runs only on request
  task automatic pulse(input int n);
    repeat (n) begin
      #80 link_clk_o = 1'b1;
      #80 link_clk_o = 1'b0;
    end
  endtask
  // Bytes from 0x70 upward, MSB first
  task automatic send_id(input logic [79:0] id, input int nbits);
    // Offset keeps link edges clear of system clock edges
    #13;
    link_frame_o = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      link_data_o = id[8 * (i / 8) + 7 - i % 8];
      pulse(1);
    end
    link_frame_o = 1'b0;
    link_data_o = ~link_data_o;
    pulse(2);
  endtask
endmodule
`default_nettype wire

// ==== bench/debug_security_id_gate_tb_top.sv ====
// Self-checking bench for the debug security ID gate
`timescale 1ns/1ps
`default_nettype none
module debug_security_id_gate_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, mon = 1'b0, sp = 1'b0;
  logic [3:0] sel = 4'h0, bsel = 4'hF;
  logic [31:0] adr = 32'h0000_0000, wd = 32'h0000_0000, q, r, dat_o;
  logic [79:0] fid = 80'h0, id;
  logic [95:0] w;
  logic [10:0] c = 11'h000, v;
  logic ack_o, fre, een, fbk, mmod, sby, pin, oe, lclk, lfr, ldat;
  int errors = 0, n_tests = 0, cycles = 0;
  always #20 clk_i = ~clk_i;
  dsig_emu_model emu (.link_clk_o(lclk), .link_frame_o(lfr), .link_data_o(ldat));
  dsig_gate dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o),
    .monitor_access_i(mon), .flash_id_i(fid), .global_interrupt_disable_i(c[0]),
    .async_receive_end_irq_mask_i(c[1]), .clocked_transfer_end_irq_mask_i(c[2]),
    .standby_i(c[3]), .standby_irq_release_off_i(c[4]), .main_clock_on_i(c[5]),
    .async_clock_mismatch_i(c[6]), .self_prog_monitor_hit_i(sp), .break_req_i(c[9]),
    .monitor_activity_i(c[10]), .direct_memory_modify_req_i(c[7]),
    .protected_reg_target_i(c[8]), .link_clk_i(lclk), .link_frame_i(lfr),
    .link_data_i(ldat), .flash_read_en_o(fre), .emulator_en_o(een),
    .forced_break_o(fbk), .direct_memory_modify_wr_o(mmod), .standby_release_o(sby),
    .debug_handshake_pin_o(pin), .debug_handshake_pin_oe_o(oe));
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    sel <= bsel;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic auth(input logic [79:0] sid);
    emu.send_id(sid, 80);
    repeat (8) @(posedge clk_i);
  endtask
  function automatic logic blk(input logic [10:0] x, input logic s);
    return x[0] | (s ? x[2] : x[1]) | (x[3] & x[4]) | (!s & !x[5]);
  endfunction
  initial begin
    r = $urandom(32'h4376);
    fork
      emu.pulse(4);
      repeat (20) @(posedge clk_i);
    join
    rst_i <= 1'b0;
    // Link side leaves reset only on its own clock edges
    emu.pulse(2);
    rd(dsig_pkg::DSIG_ADR_LINK_CTRL, 32'h0000_0000, "link_ctrl");
    rd(dsig_pkg::DSIG_ADR_STATUS, 32'h0000_0000, "status");
    rd(dsig_pkg::DSIG_ADR_PORT_MODE, 32'h0000_0000, "port_mode");
    rd(dsig_pkg::DSIG_ADR_PORT_DATA, 32'h0000_0000, "port_data");
    rd(32'h0000_0010, 32'h0000_0000, "unmapped");
    $display("test reset done");
    fid <= 80'hD423_F1DE_BC9A_7856_3412;
    auth(80'hD423_F1DE_BC9A_7856_3412);
    chk("flash_read_en", 1, fre);
    chk("emulator_en", 1, een);
    wb(1'b0, dsig_pkg::DSIG_ADR_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0003, q & 32'h0000_0003);
    r = $urandom;
    auth(80'hD423_F1DE_BC9A_7856_3412 ^ (80'hFF << (8 * (r % 10))));
    chk("flash_read_en", 0, fre);
    chk("emulator_en", 0, een);
    w = {$urandom, $urandom, $urandom};
    id = w[79:0];
    id[79] = 1'b0;
    fid <= id;
    auth(id);
    chk("flash_read_en", 1, fre);
    chk("emulator_en", 0, een);
    chk("pin_oe", 0, oe);
    id[79] = 1'b1;
    fid <= id;
    auth(id);
    chk("emulator_en", 1, een);
    emu.send_id(~id, 40);
    repeat (8) @(posedge clk_i);
    chk("emulator_en", 1, een);
    chk("flash_read_en", 1, fre);
    $display("test id done");
    wb(1'b1, dsig_pkg::DSIG_ADR_LINK_CTRL, 32'h0000_0003);
    rd(dsig_pkg::DSIG_ADR_LINK_CTRL, 32'h0000_0000, "link_ctrl");
    wb(1'b1, dsig_pkg::DSIG_ADR_PORT_MODE, 32'h0000_00FF);
    rd(dsig_pkg::DSIG_ADR_PORT_MODE, 32'h0000_00FE, "port_mode");
    bsel = 4'hE;
    wb(1'b1, dsig_pkg::DSIG_ADR_PORT_MODE, 32'h0000_0000);
    bsel = 4'hF;
    rd(dsig_pkg::DSIG_ADR_PORT_MODE, 32'h0000_00FE, "port_mode");
    wb(1'b1, dsig_pkg::DSIG_ADR_PORT_DATA, 32'h0000_0001);
    rd(dsig_pkg::DSIG_ADR_PORT_DATA, 32'h0000_0000, "port_data");
    mon <= 1'b1;
    wb(1'b1, dsig_pkg::DSIG_ADR_PORT_DATA, 32'h0000_00A5);
    rd(dsig_pkg::DSIG_ADR_PORT_DATA, 32'h0000_00A5, "port_data");
    chk("pin", 1, pin);
    chk("pin_oe", 1, oe);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, dsig_pkg::DSIG_ADR_LINK_CTRL, 32'h0000_0002 | k);
      for (int i = 0; i < 24; i++) begin
        r = $urandom;
        v = (i == 0) ? 11'h6A0 : r[10:0];
        @(posedge clk_i);
        c <= v;
        #5;
        chk("forced_break", v[9] & !blk(v, k[0]), fbk);
        chk("modify_wr", v[7] & !v[8] & !blk(v, k[0]) & !(!k[0] & v[6]), mmod);
        if (!v[0] && !v[4] && !(k[0] ? v[2] : v[1]) && !(!k[0] && v[6])) begin
          chk("standby_release", v[10] & v[3] & (k[0] | v[5]), sby);
        end
      end
    end
    @(posedge clk_i);
    c <= 11'h000;
    $display("test conditions done");
    sp <= 1'b1;
    wb(1'b0, dsig_pkg::DSIG_ADR_STATUS, 32'h0000_0000);
    chk("broken", 1, q[4]);
    chk("emulator_en", 0, een);
    $display("test self_prog done");
    give_verdict();
  end
endmodule
`default_nettype wire
